// [adc_cfg_map.svh]
// register offsets, field positions, reset values and timing figures
// assumes inclusion by the register bank package and module only
`ifndef ADC_CFG_MAP_SVH
`define ADC_CFG_MAP_SVH
`define ADDR_W              13
`define OFS_SELF_TEST       13'h000E
`define OFS_CM_CTRL         13'h000F
`define OFS_OFFSET_TRIM     13'h0010
`define OFS_OUT_FORMAT      13'h0014
`define OFS_DIV_PHASE       13'h0016
`define OFS_DCLK_DELAY      13'h0017
`define OFS_SPAN_SEL        13'h0018
`define OFS_SIG_LOW         13'h0024
`define RST_SELF_TEST       8'h04
`define RST_CM_CTRL         8'h00
`define RST_OFFSET_TRIM     8'h00
`define RST_OUT_FORMAT      8'h00
`define RST_DIV_PHASE       8'h00
`define RST_DCLK_DELAY      8'h00
`define RST_SPAN_SEL        8'hC0
`define RD_UNMAPPED         8'h00
`define BIT_ST_ENABLE       0
`define BIT_ST_RESTART      2
`define BIT_CM_SERVO        0
`define BIT_FMT_LO          0
`define BIT_FMT_HI          1
`define BIT_OUT_INVERT      2
`define BIT_OUT_DISABLE     4
`define BIT_OUT_TYPE        6
`define BIT_DCLK_INVERT     7
`define DCLK_FULL_PS        2500
`define DCLK_STEPS          31
`define SAMPLE_W            14
`define SAMPLE_MAX          14'h3FFF
`define PHASE_MAX           7
`endif

// [adc_cfg_pkg.sv]
// types shared by the converter configuration register bank
// assumes adc_cfg_map.svh is on the include path
`include "adc_cfg_map.svh"
package adc_cfg_pkg;
  // one register access from the serial port shifter
  typedef struct packed {
    logic                 wr;
    logic                 rd;
    logic [`ADDR_W-1:0]   addr;
    logic [7:0]           wdata;
  } reg_req_t;

  // output data coding
  typedef enum logic [1:0] {
    FMT_OFFSET_BIN = 2'b00,
    FMT_TWOS_COMP  = 2'b01,
    FMT_GRAY       = 2'b10,
    FMT_RESERVED   = 2'b11
  } out_fmt_t;
endpackage

// [adc_config_register_bank.sv]
// configuration register bank and output data path of a dual converter
// assumes the serial port shifter delivers decoded accesses on SYS_CLK_I
// Summary of operation
// - the signed offset trim (+127 to -128 codes) is added to each channel's result.
// - the divider tick is delayed by the 3-bit phase count plus one register cycle, so zero gives one cycle.
// - the data clock out delay is the 5-bit code times 2500 ps over 31.
// - format code 00 presents results in offset binary.
// - each delay step is about one 31st of full scale, 81 ps and 161 ps for codes 1 and 2.
// - outputs start single ended and become differential only when software sets the type.
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg_map.svh"
module adc_config_register_bank #(
  parameter int NCH = 2
) (
  // clock, reset, enable
  input  wire logic                            SYS_CLK_I,
  input  wire logic                            RESET_I,
  input  wire logic                            CE_I,
  // register access
  input  wire adc_cfg_pkg::reg_req_t           REQ_I,
  output logic      [7:0]                      RD_DATA_O,
  // self-test engine
  input  wire logic [7:0]                      SIG_LOW_I,
  output logic                                 SELF_TEST_EN_O,
  output logic                                 SELF_TEST_RESTART_O,
  // analog controls
  output logic                                 CM_SERVO_EN_O,
  output logic      [1:0]                      SPAN_SEL_O,
  // divider and data clock out
  input  wire logic                            DIV_TICK_I,
  output logic                                 DIV_TICK_O,
  output logic                                 DCLK_INVERT_O,
  output logic      [11:0]                     DCLK_DELAY_PS_O,
  // conversion data
  input  wire logic [NCH-1:0][`SAMPLE_W-1:0]   SAMPLE_I,
  output logic      [NCH-1:0][`SAMPLE_W-1:0]   DATA_O,
  output logic                                 DATA_OE_O,
  output logic                                 DIFF_SEL_O,
  // output disable pin
  input  wire logic                            OUT_DISABLE_PIN_I
);
  import adc_cfg_pkg::*;

  logic [7:0] st_ff, cm_ff, trim_ff, fmt_ff, ph_ff, dclk_ff, span_ff;
  logic [7:0] nxt_st, nxt_cm, nxt_trim, nxt_fmt, nxt_ph, nxt_dclk, nxt_span;
  logic [7:0] rd_ff, nxt_rd;

  // register writes and reads; the signature has no write path
  always_comb begin
    nxt_st   = st_ff;
    nxt_cm   = cm_ff;
    nxt_trim = trim_ff;
    nxt_fmt  = fmt_ff;
    nxt_ph   = ph_ff;
    nxt_dclk = dclk_ff;
    nxt_span = span_ff;
    nxt_rd   = rd_ff;
    if (REQ_I.wr) begin
      unique case (REQ_I.addr)
        `OFS_SELF_TEST:   nxt_st   = REQ_I.wdata;
        `OFS_CM_CTRL:     nxt_cm   = REQ_I.wdata;
        `OFS_OFFSET_TRIM: nxt_trim = REQ_I.wdata;
        `OFS_OUT_FORMAT:  nxt_fmt  = REQ_I.wdata;
        `OFS_DIV_PHASE:   nxt_ph   = REQ_I.wdata;
        `OFS_DCLK_DELAY:  nxt_dclk = REQ_I.wdata;
        `OFS_SPAN_SEL:    nxt_span = REQ_I.wdata;
        default:          nxt_st   = st_ff; // includes signature
      endcase
    end
    if (REQ_I.rd) begin
      unique case (REQ_I.addr)
        `OFS_SELF_TEST:   nxt_rd = st_ff;
        `OFS_CM_CTRL:     nxt_rd = cm_ff;
        `OFS_OFFSET_TRIM: nxt_rd = trim_ff;
        `OFS_OUT_FORMAT:  nxt_rd = fmt_ff;
        `OFS_DIV_PHASE:   nxt_rd = ph_ff;
        `OFS_DCLK_DELAY:  nxt_rd = dclk_ff;
        `OFS_SPAN_SEL:    nxt_rd = span_ff;
        `OFS_SIG_LOW:     nxt_rd = SIG_LOW_I; // live engine state
        default:          nxt_rd = `RD_UNMAPPED;
      endcase
    end
  end

  // register state
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      st_ff   <= `RST_SELF_TEST;
      cm_ff   <= `RST_CM_CTRL;
      trim_ff <= `RST_OFFSET_TRIM;
      fmt_ff  <= `RST_OUT_FORMAT;
      ph_ff   <= `RST_DIV_PHASE;
      dclk_ff <= `RST_DCLK_DELAY;
      span_ff <= `RST_SPAN_SEL;
      rd_ff   <= `RD_UNMAPPED;
    end else if (CE_I) begin
      st_ff   <= nxt_st;
      cm_ff   <= nxt_cm;
      trim_ff <= nxt_trim;
      fmt_ff  <= nxt_fmt;
      ph_ff   <= nxt_ph;
      dclk_ff <= nxt_dclk;
      span_ff <= nxt_span;
      rd_ff   <= nxt_rd;
    end
  end

  // static control outputs
  assign RD_DATA_O           = rd_ff;
  assign SELF_TEST_EN_O      = st_ff[`BIT_ST_ENABLE];
  assign SELF_TEST_RESTART_O = st_ff[`BIT_ST_RESTART];
  assign CM_SERVO_EN_O       = cm_ff[`BIT_CM_SERVO];
  assign SPAN_SEL_O          = span_ff[7:6];
  assign DCLK_INVERT_O       = ph_ff[`BIT_DCLK_INVERT];
  assign DIFF_SEL_O          = fmt_ff[`BIT_OUT_TYPE];

  // output disable pin: three stages, change taken when stages two and three agree
  logic pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_ff, nxt_pin;
  always_comb begin
    nxt_pin = (pin_s2_ff == pin_s3_ff) ? pin_s3_ff : pin_ff;
  end
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      pin_s1_ff <= 1'b0;
      pin_s2_ff <= 1'b0;
      pin_s3_ff <= 1'b0;
      pin_ff    <= 1'b0;
    end else if (CE_I) begin
      pin_s1_ff <= OUT_DISABLE_PIN_I;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      pin_ff    <= nxt_pin;
    end
  end
  assign DATA_OE_O = ~(pin_ff | fmt_ff[`BIT_OUT_DISABLE]);

  // divider tick delayed by the phase count
  logic [`PHASE_MAX-1:0] tick_sr_ff, nxt_tick_sr;
  logic                  tick_ff, nxt_tick;
  logic [2:0]            phase;
  assign phase = ph_ff[2:0];
  always_comb begin
    nxt_tick_sr = {tick_sr_ff[`PHASE_MAX-2:0], DIV_TICK_I};
    nxt_tick    = (phase == 3'h0) ? DIV_TICK_I : tick_sr_ff[phase - 3'h1];
  end
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      tick_sr_ff <= '0;
      tick_ff    <= 1'b0;
    end else if (CE_I) begin
      tick_sr_ff <= nxt_tick_sr;
      tick_ff    <= nxt_tick;
    end
  end
  assign DIV_TICK_O = tick_ff;

  // data clock out delay in ps, rounded to nearest
  logic [16:0] dclk_prod;
  logic [11:0] dclk_ps_ff, nxt_dclk_ps;
  always_comb begin
    dclk_prod   = 17'(dclk_ff[4:0]) * 17'(`DCLK_FULL_PS) + 17'(`DCLK_STEPS / 2);
    nxt_dclk_ps = 12'(dclk_prod / 17'(`DCLK_STEPS));
  end
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      dclk_ps_ff <= 12'h000;
    end else if (CE_I) begin
      dclk_ps_ff <= nxt_dclk_ps;
    end
  end
  assign DCLK_DELAY_PS_O = dclk_ps_ff;

  // per-channel trim, saturation and output coding
  logic [NCH-1:0][`SAMPLE_W-1:0] data_ff, nxt_data;
  out_fmt_t fmt;
  assign fmt = out_fmt_t'(fmt_ff[`BIT_FMT_HI:`BIT_FMT_LO]);
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic signed [`SAMPLE_W+1:0] sum;
    logic        [`SAMPLE_W-1:0] sat, coded;
    always_comb begin
      sum = $signed({2'b00, SAMPLE_I[c]}) + (`SAMPLE_W+2)'($signed(trim_ff));
      if (sum < 0) begin
        sat = '0;
      end else if (sum > $signed({2'b00, `SAMPLE_MAX})) begin
        sat = `SAMPLE_MAX;
      end else begin
        sat = sum[`SAMPLE_W-1:0];
      end
      unique case (fmt)
        FMT_TWOS_COMP: coded = {~sat[`SAMPLE_W-1], sat[`SAMPLE_W-2:0]};
        FMT_GRAY:      coded = sat ^ (sat >> 1);
        default:       coded = sat; // offset binary
      endcase
      nxt_data[c] = fmt_ff[`BIT_OUT_INVERT] ? ~coded : coded;
    end
  end
  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      data_ff <= '0;
    end else if (CE_I) begin
      data_ff <= nxt_data;
    end
  end
  assign DATA_O = data_ff;

  // checks
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RESET_I);

  a_trim_zero_pass: assert property (CE_I && trim_ff == 8'h00 && fmt_ff[2:0] == 3'b000
      |=> DATA_O[0] == $past(SAMPLE_I[0])) else $error("plain sample not passed");
  a_trim_saturate: assert property (CE_I && SAMPLE_I[0] == 14'h3FF0 && trim_ff == 8'h7F
      && fmt_ff[2:0] == 3'b000 |=> DATA_O[0] == 14'h3FFF) else $error("no saturation");
  a_trim_negative: assert property (CE_I && SAMPLE_I[0] == 14'h2000 && trim_ff == 8'h80
      && fmt_ff[2:0] == 3'b000 |=> DATA_O[0] == 14'h1F80) else $error("bad negative trim");
  a_phase_zero: assert property (CE_I && phase == 3'h0 && DIV_TICK_I
      |=> DIV_TICK_O) else $error("zero phase tick late");
  a_phase_three: assert property ((CE_I && phase == 3'h3 && DIV_TICK_I)
      ##1 (CE_I && phase == 3'h3)[*3] |=> DIV_TICK_O) else $error("phase delay wrong");
  a_dclk_full: assert property (CE_I && dclk_ff[4:0] == 5'h1F
      |=> DCLK_DELAY_PS_O == 12'h9C4) else $error("full delay wrong");
  a_dclk_steps: assert property (CE_I && dclk_ff[4:0] == 5'h02
      |=> DCLK_DELAY_PS_O == 12'h0A1) else $error("delay step wrong");
  a_diff_by_write: assert property ($rose(DIFF_SEL_O) |-> $past(CE_I) && $past(REQ_I.wr)
      && $past(REQ_I.addr) == `OFS_OUT_FORMAT) else $error("type changed unasked");
  a_sig_read: assert property (CE_I && REQ_I.rd && REQ_I.addr == `OFS_SIG_LOW
      |=> RD_DATA_O == $past(SIG_LOW_I)) else $error("signature read wrong");
  a_pin_disables: assert property ((CE_I && OUT_DISABLE_PIN_I)[*5]
      |=> !DATA_OE_O) else $error("pin did not disable");
endmodule
`default_nettype wire

// [adc_config_register_bank_tb.sv]
// self-checking bench of the converter configuration register bank
// assumes the host model file and the design package are compiled first
`timescale 1ns/1ps
`default_nettype none
module adc_config_register_bank_tb;
  import adc_cfg_pkg::*;
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic             tick = 1'b0;
  logic [7:0]       sig = 8'h5A;
  logic [1:0][13:0] smp = '0;
  logic [1:0][13:0] dat;
  logic [11:0]      dly;
  logic [7:0]       rdd;
  logic             tko, oe, dif, pin, ste, str, cms, dinv;
  logic [1:0]       spn;
  reg_req_t         req;
  int               err_count = 0;
  int               samples_checked = 0;
  // 125 MHz clock
  always #4 clk = ~clk;
  host_model host_model_inst (.clk_i(clk), .req_o(req), .pin_o(pin));
  adc_config_register_bank #(.NCH(2)) adc_config_register_bank_inst (
    .SYS_CLK_I(clk), .RESET_I(rst), .CE_I(1'b1), .REQ_I(req), .RD_DATA_O(rdd),
    .SIG_LOW_I(sig), .SELF_TEST_EN_O(ste), .SELF_TEST_RESTART_O(str), .CM_SERVO_EN_O(cms),
    .SPAN_SEL_O(spn), .DIV_TICK_I(tick), .DIV_TICK_O(tko), .DCLK_INVERT_O(dinv),
    .DCLK_DELAY_PS_O(dly), .SAMPLE_I(smp), .DATA_O(dat), .DATA_OE_O(oe),
    .DIFF_SEL_O(dif), .OUT_DISABLE_PIN_I(pin));
  // compare and count
  task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask
  // read one register and compare
  task automatic rd_chk(input logic [12:0] a, input logic [7:0] e);
    host_model_inst.xfer(1'b0, a, 8'h00);
    chk("read data", {8'h00, rdd}, {8'h00, e});
  endtask
  // reset values, signature and an unmapped read
  task automatic t_reset();
    logic [12:0] a[9] = '{13'h0E, 13'h0F, 13'h10, 13'h14, 13'h16, 13'h17, 13'h18, 13'h24, 13'h1FF};
    logic [7:0]  e[9] = '{8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hC0, 8'h5A, 8'h00};
    for (int i = 0; i < 9; i++) rd_chk(a[i], e[i]);
    chk("diff select", {15'h0, dif}, 16'h0000);
    chk("outputs off", {15'h0, oe}, 16'h0000);
    chk("self-test en", {15'h0, ste}, 16'h0000);
    chk("self-test restart", {15'h0, str}, 16'h0001);
    chk("servo en", {15'h0, cms}, 16'h0000);
    chk("span select", {14'h0, spn}, 16'h0003);
    chk("clock invert", {15'h0, dinv}, 16'h0000);
    $display("test reset done");
  endtask
  // output type, enable and read-only signature
  task automatic t_mode();
    host_model_inst.xfer(1'b1, 13'h14, 8'h40);
    chk("diff select", {15'h0, dif}, 16'h0001);
    host_model_inst.release_pin();
    repeat (8) @(negedge clk);
    chk("outputs on", {15'h0, oe}, 16'h0001);
    host_model_inst.xfer(1'b1, 13'h14, 8'h10);
    chk("diff select", {15'h0, dif}, 16'h0000);
    chk("outputs off", {15'h0, oe}, 16'h0000);
    host_model_inst.xfer(1'b1, 13'h14, 8'h00);
    host_model_inst.xfer(1'b1, 13'h24, 8'hFF);
    rd_chk(13'h24, 8'h5A);
    host_model_inst.xfer(1'b1, 13'h0E, 8'h01);
    host_model_inst.xfer(1'b1, 13'h0F, 8'h01);
    host_model_inst.xfer(1'b1, 13'h18, 8'h40);
    chk("self-test en", {15'h0, ste}, 16'h0001);
    chk("self-test restart", {15'h0, str}, 16'h0000);
    chk("servo en", {15'h0, cms}, 16'h0001);
    chk("span select", {14'h0, spn}, 16'h0001);
    $display("test mode done");
  endtask
  // data clock delay codes
  task automatic t_dclk();
    logic [4:0]  c[5] = '{5'h00, 5'h01, 5'h02, 5'h1E, 5'h1F};
    logic [11:0] e[5] = '{12'h000, 12'h051, 12'h0A1, 12'h973, 12'h9C4};
    for (int i = 0; i < 5; i++) begin
      host_model_inst.xfer(1'b1, 13'h17, {3'b000, c[i]});
      @(negedge clk);
      chk("delay ps", {4'h0, dly}, {4'h0, e[i]});
    end
    host_model_inst.xfer(1'b1, 13'h16, 8'h80);
    chk("clock invert", {15'h0, dinv}, 16'h0001);
    $display("test dclk done");
  endtask
  // divider phase for every code
  task automatic t_phase();
    int m;
    for (int p = 0; p < 8; p++) begin
      host_model_inst.xfer(1'b1, 13'h16, p[7:0]);
      tick = 1'b1;
      @(negedge clk);
      tick = 1'b0;
      m = 1;
      while (tko !== 1'b1 && m < 20) begin
        @(negedge clk);
        m++;
      end
      chk("tick delay", m[15:0], 16'(p + 1));
    end
    $display("test phase done");
  endtask
  // signed trim with saturation in offset binary, then each output coding and inversion
  task automatic t_data();
    logic [7:0]  f[4]  = '{8'h01, 8'h02, 8'h04, 8'h03};
    logic [13:0] e0[4] = '{14'h1FFF, 14'h2000, 14'h0000, 14'h3FFF};
    logic [13:0] e1[4] = '{14'h007F, 14'h3040, 14'h1F80, 14'h207F};
    smp = '{14'h0005, 14'h2000};
    host_model_inst.xfer(1'b1, 13'h10, 8'h80);
    repeat (3) @(negedge clk);
    chk("data ch0", {2'b00, dat[0]}, 16'h1F80);
    chk("data ch1", {2'b00, dat[1]}, 16'h0000);
    smp = '{14'h2000, 14'h3FF0};
    host_model_inst.xfer(1'b1, 13'h10, 8'h7F);
    repeat (3) @(negedge clk);
    chk("data ch0", {2'b00, dat[0]}, 16'h3FFF);
    chk("data ch1", {2'b00, dat[1]}, 16'h207F);
    for (int i = 0; i < 4; i++) begin
      host_model_inst.xfer(1'b1, 13'h14, f[i]);
      @(negedge clk);
      chk("coded ch0", {2'b00, dat[0]}, {2'b00, e0[i]});
      chk("coded ch1", {2'b00, dat[1]}, {2'b00, e1[i]});
    end
    $display("test data done");
  endtask
  // verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_mode();
    t_dclk();
    t_phase();
    t_data();
    conclude();
  end
  // watchdog well beyond the roughly 150 cycles the tests take
  initial begin
    #200000;
    err_count++;
    conclude();
  end
endmodule
`default_nettype wire

// [host_model.sv]
// serial port host stand-in: register accesses and the output disable pin
// assumes accesses are launched on falling edges of the shared clock
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // clock
  input  wire logic                clk_i,
  // register access and pin
  output var adc_cfg_pkg::reg_req_t req_o,
  output var logic                 pin_o
);
  import adc_cfg_pkg::*;
  // idle bus, pin held high from power-up
  initial begin
    req_o = '0;
    pin_o = 1'b1;
  end
  // one-cycle strobe; released fields show the inverse, not the old value
  task automatic xfer(input logic w, input logic [12:0] a, input logic [7:0] d);
    @(negedge clk_i);
    req_o = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge clk_i);
    req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // pin driven low so outputs may be enabled, whatever the output type
  task automatic release_pin();
    pin_o = 1'b0;
  endtask
endmodule
`default_nettype wire
